// File: dv/t16cc_regs_bench.sv
// Purpose: directed register-level test of the dual timer block
// Assumes: inputs change at the falling edge, no prescaler model
// Notes: ticks are driven by hand so counts stay exact
`timescale 1ns/1ps
module t16cc_regs_bench
  import t16cc_pkg::*;
();
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  t16cc_bus_req_type bus_req = '0;
  logic [7:0] bus_rdata;
  logic [NTMR-1:0] tick = '0;
  logic [NTMR-1:0][3:0] wgm = '0;
  logic [NTMR-1:0][NCH-1:0][1:0] com = '0;
  logic [NTMR-1:0] cap_pin = '0;
  logic [NTMR-1:0] cap_rise = '1;
  logic acmp = 1'b0;
  logic acmp_sel = 1'b0;
  logic gie = 1'b0;
  logic [NTMR-1:0][7:0] ack = '0;
  logic [NTMR-1:0][NCH-1:0] cout;
  logic [NTMR-1:0][7:0] irq;
  int num_errors = 0;
  int checks_done = 0;
  always #4 clk_sys = ~clk_sys;
  t16cc_regs u_t16cc_regs (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_tick(tick), .waveform_mode_sel(wgm),
    .compare_output_mode(com), .capture_input_pin(cap_pin), .capture_rising_edge(cap_rise),
    .analog_comp_out(acmp), .analog_comp_capture_sel(acmp_sel), .global_irq_enable(gie),
    .irq_vector_ack(ack), .compare_out(cout), .irq_request(irq));
  // ----------------------------------------
  // bus, tick and verdict tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic t, input logic [3:0] o, input logic [7:0] d);
    @(negedge clk_sys);
    bus_req = '{tmr_sel: t, offset: o, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys);
    bus_req.wr = 1'b0;
  endtask : reg_wr
  // high byte first so the low write commits both halves
  task automatic wr16(input logic t, input logic [3:0] o, input logic [15:0] v);
    reg_wr(t, o + 4'h1, v[15:8]);
    reg_wr(t, o, v[7:0]);
  endtask : wr16
  task automatic rd_chk(input logic t, input logic [3:0] o, input logic [7:0] e);
    @(negedge clk_sys);
    bus_req = '{tmr_sel: t, offset: o, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys);
    bus_req.rd = 1'b0;
    check(16'(bus_rdata), 16'(e));
  endtask : rd_chk
  task automatic pulse(input int t, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      tick[t] = 1'b1;
      @(negedge clk_sys);
      tick[t] = 1'b0;
    end
    repeat (3) @(negedge clk_sys);
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #50us;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    for (int t = 0; t < NTMR; t++) begin
      for (int o = 0; o < 16; o++) begin
        rd_chk(t[0], o[3:0], REG_RESET);
      end
    end
    $display("test reset values done");
    com[0] = {COM_SET, COM_CLEAR, COM_TOGGLE};
    com[1] = {COM_SET, COM_SET, COM_SET};
    reg_wr(1'b0, OFF_CTRL_C, FORCE_BITS_T1);
    reg_wr(1'b1, OFF_CTRL_C, FORCE_BITS_T1);
    pulse(0, 0);
    check(16'(cout[0]), 16'h0005);
    check(16'(cout[1]), 16'h0001);
    rd_chk(1'b0, OFF_FLAG, REG_RESET);
    wgm[0] = WGM_FP8;
    reg_wr(1'b0, OFF_CTRL_C, FORCE_BITS_T1);
    pulse(0, 0);
    check(16'(cout[0]), 16'h0005);
    wgm[0] = WGM_NORMAL;
    $display("test force strobes done");
    gie = 1'b1;
    reg_wr(1'b0, OFF_MASK, 8'hFF);
    rd_chk(1'b0, OFF_MASK, IRQ_BITS);
    wr16(1'b0, OFF_CMP_BASE, 16'h0005);
    reg_wr(1'b0, OFF_CMP_BASE + 4'h1, 8'h7E);
    rd_chk(1'b0, OFF_CMP_BASE + 4'h1, 8'h00);
    wr16(1'b0, OFF_CNT_L, 16'h0003);
    pulse(0, 3);
    rd_chk(1'b0, OFF_FLAG, 8'h02);
    check(16'(irq[0]), 16'h0002);
    check(16'(cout[0]), 16'h0004);
    reg_wr(1'b0, OFF_FLAG, 8'h00);
    rd_chk(1'b0, OFF_FLAG, 8'h02);
    reg_wr(1'b0, OFF_FLAG, 8'h02);
    rd_chk(1'b0, OFF_FLAG, 8'h00);
    wr16(1'b0, OFF_CNT_L, 16'h0005);
    pulse(0, 1);
    rd_chk(1'b0, OFF_FLAG, 8'h00);
    $display("test compare match done");
    wr16(1'b0, OFF_CNT_L, 16'hA1B2);
    rd_chk(1'b0, OFF_CNT_L, 8'hB2);
    rd_chk(1'b0, OFF_CNT_H, 8'hA1);
    wr16(1'b0, OFF_CNT_L, CNT_MAX);
    pulse(0, 1);
    rd_chk(1'b0, OFF_FLAG, 8'h01);
    check(16'(irq[0]), 16'h0001);
    ack[0][BIT_OVF] = 1'b1;
    @(negedge clk_sys);
    ack[0][BIT_OVF] = 1'b0;
    rd_chk(1'b0, OFF_FLAG, 8'h00);
    $display("test overflow done");
    wr16(1'b1, OFF_CNT_L, 16'h1234);
    cap_pin[1] = 1'b1;
    pulse(1, 0);
    rd_chk(1'b1, OFF_CAP_L, 8'h34);
    rd_chk(1'b1, OFF_CAP_H, 8'h12);
    rd_chk(1'b1, OFF_FLAG, 8'h20);
    reg_wr(1'b1, OFF_FLAG, 8'h20);
    wgm[1] = WGM_CTC_CAP;
    wr16(1'b1, OFF_CNT_L, 16'h0777);
    cap_pin[1] = 1'b0;
    pulse(1, 0);
    cap_pin[1] = 1'b1;
    pulse(1, 0);
    rd_chk(1'b1, OFF_CAP_L, 8'h34);
    rd_chk(1'b1, OFF_FLAG, 8'h00);
    acmp_sel = 1'b1;
    wr16(1'b0, OFF_CNT_L, 16'h0ABC);
    acmp = 1'b1;
    pulse(0, 0);
    rd_chk(1'b0, OFF_CAP_L, 8'hBC);
    rd_chk(1'b0, OFF_CAP_H, 8'h0A);
    wr16(1'b1, OFF_CNT_L, 16'h1234);
    pulse(1, 1);
    rd_chk(1'b1, OFF_FLAG, 8'h20);
    reg_wr(1'b1, OFF_MASK, 8'h20);
    pulse(1, 0);
    check(16'(irq[1]), 16'h0020);
    reg_wr(1'b1, OFF_FLAG, 8'h20);
    wgm[1] = WGM_NORMAL;
    cap_rise[1] = 1'b0;
    wr16(1'b1, OFF_CNT_L, 16'h5678);
    cap_pin[1] = 1'b0;
    pulse(1, 0);
    rd_chk(1'b1, OFF_CAP_L, 8'h78);
    rd_chk(1'b1, OFF_CAP_H, 8'h56);
    rd_chk(1'b1, OFF_FLAG, 8'h20);
    $display("test capture done");
    wr16(1'b0, OFF_CNT_L, CNT_MAX);
    // overflow set and write-one clear land on the same edge
    fork
      reg_wr(1'b0, OFF_FLAG, 8'h21);
      pulse(0, 1);
    join
    rd_chk(1'b0, OFF_FLAG, 8'h01);
    gie = 1'b0;
    pulse(0, 0);
    check(16'(irq[0]), 16'h0000);
    gie = 1'b1;
    reg_wr(1'b0, OFF_FLAG, 8'h01);
    wgm[0] = WGM_FP8;
    wr16(1'b0, OFF_CNT_L, TOP_8BIT);
    pulse(0, 1);
    rd_chk(1'b0, OFF_FLAG, 8'h01);
    wgm[0] = WGM_NORMAL;
    $display("test flag priority done");
    print_verdict();
  end
endmodule : t16cc_regs_bench

// File: dv/t16cc_regs_properties.sv
// Purpose: port-level assertions for the dual timer register block
// Assumes: bus and flag latencies as handed over with the design
// Notes: watches timer one for output and vector timing
`timescale 1ns/1ps
module t16cc_regs_properties
  import t16cc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire t16cc_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [NTMR-1:0] timer_tick,
  input wire logic global_irq_enable,
  input wire logic [NTMR-1:0][7:0] irq_vector_ack,
  input wire logic [NTMR-1:0][NCH-1:0] compare_out,
  input wire logic [NTMR-1:0][7:0] irq_request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence rd_at(logic [3:0] o);
    bus_req.rd && bus_req.offset == o;
  endsequence
  ctrl_c_zero_a: assert property (rd_at(OFF_CTRL_C) |=> bus_rdata == REG_RESET)
    else $error("control C read not zero");
  unmapped_zero_a: assert property (bus_req.rd && bus_req.offset > OFF_CTRL_C |=> bus_rdata == 0)
    else $error("unmapped read not zero");
  mask_resv_a: assert property (rd_at(OFF_MASK) |=> (bus_rdata & ~IRQ_BITS) == 0)
    else $error("mask reserved bits set");
  flag_resv_a: assert property (rd_at(OFF_FLAG) |=> (bus_rdata & ~IRQ_BITS) == 0)
    else $error("flag reserved bits set");
  rdata_hold_a: assert property (!bus_req.rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  resv_req_a: assert property (((irq_request[0] | irq_request[1]) & ~IRQ_BITS) == 0)
    else $error("request on reserved bit");
  global_gate_a: assert property (!global_irq_enable |=> irq_request == '0)
    else $error("request while globally disabled");
  out_cause_a: assert property ($changed(compare_out[0]) |->
    $past(timer_tick[0], 2) || $past(bus_req.wr) || $past(bus_req.wr, 2))
    else $error("compare output moved without cause");
  ack_clear_a: assert property (irq_vector_ack[0][BIT_OVF] && !timer_tick[0]
    |-> ##2 !irq_request[0][BIT_OVF])
    else $error("vector did not clear overflow");
endmodule : t16cc_regs_properties

bind t16cc_regs t16cc_regs_properties u_t16cc_regs_properties (
  .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .timer_tick(timer_tick), .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .compare_out(compare_out), .irq_request(irq_request));

// File: rtl/t16cc_pkg.sv
// Purpose: shared constants and types of the dual 16-bit timer register block
// Assumes: 8-bit register port, one timer clock tick input per timer
// Notes: address = {timer select, register offset}
package t16cc_pkg;

  localparam int NTMR = 2;
  localparam int NCH = 3;

  // ----------------------------------------
  // register offsets inside one timer
  // ----------------------------------------
  localparam logic [3:0] OFF_CNT_L = 4'h0;
  localparam logic [3:0] OFF_CNT_H = 4'h1;
  localparam logic [3:0] OFF_CMP_BASE = 4'h2;
  localparam logic [3:0] OFF_CAP_L = 4'h8;
  localparam logic [3:0] OFF_CAP_H = 4'h9;
  localparam logic [3:0] OFF_MASK = 4'hA;
  localparam logic [3:0] OFF_FLAG = 4'hB;
  localparam logic [3:0] OFF_CTRL_C = 4'hC;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int BIT_OVF = 0;
  localparam int BIT_CMP_A = 1;
  localparam int BIT_CAP = 5;
  localparam int BIT_FORCE_A = 7;
  localparam logic [7:0] IRQ_BITS = 8'h2F;
  localparam logic [7:0] FORCE_BITS_T1 = 8'hE0;
  localparam logic [7:0] FORCE_BITS_T3 = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [3:0] {
    WGM_NORMAL = 4'b0000, WGM_PC8 = 4'b0001, WGM_PC9 = 4'b0010, WGM_PC10 = 4'b0011,
    WGM_CTC_CMP = 4'b0100, WGM_FP8 = 4'b0101, WGM_FP9 = 4'b0110, WGM_FP10 = 4'b0111,
    WGM_PFC_CAP = 4'b1000, WGM_PFC_CMP = 4'b1001, WGM_PC_CAP = 4'b1010,
    WGM_PC_CMP = 4'b1011, WGM_CTC_CAP = 4'b1100, WGM_RSVD = 4'b1101,
    WGM_FP_CAP = 4'b1110, WGM_FP_CMP = 4'b1111
  } t16cc_wgm_type;

  typedef struct packed {
    logic tmr_sel;
    logic [3:0] offset;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } t16cc_bus_req_type;

endpackage : t16cc_pkg

// File: rtl/t16cc_regs.sv
// Purpose: counter, compare, capture, mask and flag registers of timers one and three
// Assumes: timer_tick pulses come from the prescaler; inputs synchronous to clk_sys
// Notes: index 0 is timer one, index 1 is timer three
`timescale 1ns/1ps

module t16cc_regs
  import t16cc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire t16cc_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  input wire logic [NTMR-1:0] timer_tick,
  input wire logic [NTMR-1:0][3:0] waveform_mode_sel,
  input wire logic [NTMR-1:0][NCH-1:0][1:0] compare_output_mode,
  input wire logic [NTMR-1:0] capture_input_pin,
  input wire logic [NTMR-1:0] capture_rising_edge,
  input wire logic analog_comp_out,
  input wire logic analog_comp_capture_sel,
  input wire logic global_irq_enable,
  input wire logic [NTMR-1:0][7:0] irq_vector_ack,
  output logic [NTMR-1:0][NCH-1:0] compare_out,
  output logic [NTMR-1:0][7:0] irq_request
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic mode_is_pwm(input logic [3:0] m);
    return !(m == WGM_NORMAL || m == WGM_CTC_CMP || m == WGM_CTC_CAP);
  endfunction : mode_is_pwm

  function automatic logic mode_cap_top(input logic [3:0] m);
    return m == WGM_PFC_CAP || m == WGM_PC_CAP || m == WGM_CTC_CAP || m == WGM_FP_CAP;
  endfunction : mode_cap_top

  function automatic logic mode_cmp_top(input logic [3:0] m);
    return m == WGM_CTC_CMP || m == WGM_PFC_CMP || m == WGM_PC_CMP || m == WGM_FP_CMP;
  endfunction : mode_cmp_top

  function automatic logic apply_com(input logic cur, input logic [1:0] com);
    case (com)
      COM_TOGGLE: return !cur;
      COM_CLEAR: return 1'b0;
      COM_SET: return 1'b1;
      default: return cur;
    endcase
  endfunction : apply_com

  function automatic logic is_cmp_offset(input logic [3:0] off);
    return off >= OFF_CMP_BASE && off < OFF_CAP_L;
  endfunction : is_cmp_offset

  // both bytes of one compare register map to the same channel
  function automatic logic [1:0] cmp_channel(input logic [3:0] off);
    return 2'((off - OFF_CMP_BASE) >> 1);
  endfunction : cmp_channel

  function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction : pick_byte

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [NTMR-1:0][15:0] counter_value;
  logic [NTMR-1:0][NCH-1:0][15:0] compare_value;
  logic [NTMR-1:0][15:0] capture_value;
  logic [NTMR-1:0][7:0] irq_mask_reg;
  logic [NTMR-1:0][7:0] irq_flag_reg;
  logic [7:0] high_latch;
  logic [NTMR-1:0] match_block;
  logic [NTMR-1:0][NCH-1:0] match_hit;
  logic [NTMR-1:0] capture_prev;

  logic [NTMR-1:0][15:0] top_value;
  logic [NTMR-1:0] at_top;
  logic [NTMR-1:0] cnt_write;
  logic [NTMR-1:0] ctrl_c_write;
  logic [NTMR-1:0] capture_event;
  logic [NTMR-1:0] overflow_event;
  logic [NTMR-1:0][7:0] next_flag_set;
  logic [NTMR-1:0][7:0] next_flag_clear;
  logic [NTMR-1:0] capture_src;

  // ----------------------------------------
  // decode and events
  // ----------------------------------------
  always_comb begin
    for (int t = 0; t < NTMR; t++) begin
      if (mode_cap_top(waveform_mode_sel[t])) begin
        top_value[t] = capture_value[t];
      end else if (mode_cmp_top(waveform_mode_sel[t])) begin
        top_value[t] = compare_value[t][0];
      end else if (waveform_mode_sel[t][1:0] == 2'b01) begin
        top_value[t] = TOP_8BIT;
      end else if (waveform_mode_sel[t][1:0] == 2'b10) begin
        top_value[t] = TOP_9BIT;
      end else if (waveform_mode_sel[t][1:0] == 2'b11) begin
        top_value[t] = TOP_10BIT;
      end else begin
        top_value[t] = CNT_MAX;
      end
      at_top[t] = counter_value[t] == top_value[t];
      cnt_write[t] = bus_req.wr && bus_req.tmr_sel == t[0] && bus_req.offset == OFF_CNT_L;
      ctrl_c_write[t] = bus_req.wr && bus_req.tmr_sel == t[0] && bus_req.offset == OFF_CTRL_C;
      // timer one may capture from the analog comparator instead of its pin
      capture_src[t] = (t == 0 && analog_comp_capture_sel) ? analog_comp_out
                                                           : capture_input_pin[t];
      capture_event[t] = (capture_rising_edge[t] ? (capture_src[t] && !capture_prev[t])
                                                 : (!capture_src[t] && capture_prev[t]))
                         && !mode_cap_top(waveform_mode_sel[t]);
      // non-PWM modes flag at MAX; PWM modes flag where the counter wraps to bottom
      overflow_event[t] = timer_tick[t] && (mode_is_pwm(waveform_mode_sel[t])
                          ? at_top[t] : counter_value[t] == CNT_MAX);
      next_flag_set[t] = REG_RESET;
      next_flag_set[t][BIT_OVF] = overflow_event[t];
      for (int c = 0; c < NCH; c++) begin
        next_flag_set[t][BIT_CMP_A + c] = match_hit[t][c];
      end
      next_flag_set[t][BIT_CAP] = capture_event[t] ||
        (mode_cap_top(waveform_mode_sel[t]) && timer_tick[t] && at_top[t]);
      next_flag_clear[t] = irq_vector_ack[t];
      if (bus_req.wr && bus_req.tmr_sel == t[0] && bus_req.offset == OFF_FLAG) begin
        next_flag_clear[t] = next_flag_clear[t] | bus_req.wdata;
      end
    end
  end

  // ----------------------------------------
  // counter and compare match
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      if (!reset_n) begin
        counter_value[t] <= CNT_ZERO;
      end else if (cnt_write[t]) begin
        counter_value[t] <= {high_latch, bus_req.wdata};
      end else if (timer_tick[t]) begin
        counter_value[t] <= at_top[t] ? CNT_ZERO : counter_value[t] + 16'h0001;
      end
    end
  end

  // the block lasts until the first tick after the write, whenever that comes
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      if (!reset_n) begin
        match_block[t] <= 1'b0;
      end else if (cnt_write[t]) begin
        match_block[t] <= 1'b1;
      end else if (timer_tick[t]) begin
        match_block[t] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      for (int c = 0; c < NCH; c++) begin
        if (!reset_n) begin
          match_hit[t][c] <= 1'b0;
        end else begin
          match_hit[t][c] <= timer_tick[t] && !match_block[t] && !cnt_write[t]
                             && counter_value[t] == compare_value[t][c];
        end
      end
    end
  end

  // ----------------------------------------
  // compare outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      for (int c = 0; c < NCH; c++) begin
        if (!reset_n) begin
          compare_out[t][c] <= 1'b0;
        end else if (match_hit[t][c]) begin
          compare_out[t][c] <= apply_com(compare_out[t][c], compare_output_mode[t][c]);
        end else if (ctrl_c_write[t] && !mode_is_pwm(waveform_mode_sel[t])
                     && bus_req.wdata[BIT_FORCE_A - c]
                     && (t == 0 ? FORCE_BITS_T1[BIT_FORCE_A - c]
                                : FORCE_BITS_T3[BIT_FORCE_A - c])) begin
          // strobe only: no flag, no counter clear, current mode bits decide
          compare_out[t][c] <= apply_com(compare_out[t][c], compare_output_mode[t][c]);
        end
      end
    end
  end

  // ----------------------------------------
  // compare and capture registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      for (int c = 0; c < NCH; c++) begin
        if (!reset_n) begin
          compare_value[t][c] <= CNT_ZERO;
        end else if (bus_req.wr && bus_req.tmr_sel == t[0]
                     && bus_req.offset == OFF_CMP_BASE + 4'(2 * c)) begin
          compare_value[t][c] <= {high_latch, bus_req.wdata};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      if (!reset_n) begin
        capture_value[t] <= CNT_ZERO;
        // follow the pin during reset so a pin idling high gives no false edge
        capture_prev[t] <= capture_src[t];
      end else begin
        capture_prev[t] <= capture_src[t];
        if (capture_event[t]) begin
          capture_value[t] <= counter_value[t];
        end else if (bus_req.wr && bus_req.tmr_sel == t[0] && bus_req.offset == OFF_CAP_L) begin
          capture_value[t] <= {high_latch, bus_req.wdata};
        end
      end
    end
  end

  // ----------------------------------------
  // mask, flags and requests
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      if (!reset_n) begin
        irq_mask_reg[t] <= REG_RESET;
      end else if (bus_req.wr && bus_req.tmr_sel == t[0] && bus_req.offset == OFF_MASK) begin
        irq_mask_reg[t] <= bus_req.wdata & IRQ_BITS;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      if (!reset_n) begin
        irq_flag_reg[t] <= REG_RESET;
      end else begin
        // set is applied after clear so a same-cycle event survives
        irq_flag_reg[t] <= ((irq_flag_reg[t] & ~next_flag_clear[t]) | next_flag_set[t])
                           & IRQ_BITS;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < NTMR; t++) begin
      if (!reset_n) begin
        irq_request[t] <= REG_RESET;
      end else begin
        irq_request[t] <= irq_flag_reg[t] & irq_mask_reg[t] & {8{global_irq_enable}};
      end
    end
  end

  // ----------------------------------------
  // shared high byte latch and read data
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      high_latch <= REG_RESET;
    end else if (bus_req.wr && bus_req.offset < OFF_MASK && bus_req.offset[0]) begin
      high_latch <= bus_req.wdata;
    end else if (bus_req.rd && bus_req.offset == OFF_CNT_L) begin
      high_latch <= counter_value[bus_req.tmr_sel][15:8];
    end else if (bus_req.rd && bus_req.offset == OFF_CAP_L) begin
      high_latch <= capture_value[bus_req.tmr_sel][15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_rdata <= REG_RESET;
    end else if (bus_req.rd) begin
      case (bus_req.offset)
        OFF_CNT_L: bus_rdata <= counter_value[bus_req.tmr_sel][7:0];
        OFF_CAP_L: bus_rdata <= capture_value[bus_req.tmr_sel][7:0];
        OFF_CNT_H, OFF_CAP_H: bus_rdata <= high_latch;
        OFF_MASK: bus_rdata <= irq_mask_reg[bus_req.tmr_sel];
        OFF_FLAG: bus_rdata <= irq_flag_reg[bus_req.tmr_sel];
        OFF_CTRL_C: bus_rdata <= REG_RESET;
        // compare bytes are read directly, without the shared latch
        default: begin
          if (is_cmp_offset(bus_req.offset)) begin
            bus_rdata <= pick_byte(compare_value[bus_req.tmr_sel][cmp_channel(bus_req.offset)],
                                   bus_req.offset[0]);
          end else begin
            bus_rdata <= REG_RESET;
          end
        end
      endcase
    end
  end

endmodule : t16cc_regs
